// >>> common/speed_shaper_pkg.sv
// Notes on behaviour
// - swap setting 0: positive analog voltage means forward, negative reverse.
// - swap setting 1: positive analog voltage means reverse, negative forward.
// - eight signed internal speeds, range +/-20000 mm/s, reset to zero.
// - sign of an internal speed gives its direction, positive is forward.
// - internal speed magnitude clamped to overspeed level, sign kept.
// - force control limit is speed four unless external analog limit chosen.
// - acceleration time 0..10000 ms per 1000 mm/s; zero disables ramp.
// - acceleration and deceleration use separate time settings.
// - pseudo S-curve rounds corners, width setting 0..1000 in 2 ms units.
// - clamp select 0..3, default 0; 0 disables zero speed function.
// - mode 1: zero input forces command to zero through the ramp.
// - mode 2: command zeroed, lock once actual speed under lock level.
// - mode 2: releasing zero input leaves lock, back to speed control.
// - mode 2 lock drives the position command to zero.
// - mode 3: lock when zero input on and command under lock level.
// - mode 3 never zeroes the command; host must lower it.
// - lock level compared on magnitude, same for both directions.
// - source 1 speeds 1-4, 2 speeds 1-3 plus analog, 3 speeds 1-8.
package speed_shaper_pkg;
  // ----------------------------------------
  // widths
  // ----------------------------------------
  localparam int SPD_W = 16;
  localparam int ACC_W = 14;
  localparam int SCV_W = 10;
  localparam int CRD_W = 16;
  localparam int NUM_SPEEDS = 8;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_HZ = 32'h02fa_f080;
  localparam int TICK_MS = 1;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam logic [CRD_W-1:0] CREDIT_INC = 16'h03e8;
  localparam logic [CRD_W-1:0] CREDIT_CAP = 16'h4e20;
  // ----------------------------------------
  // setting encodings
  // ----------------------------------------
  localparam logic [1:0] ZC_OFF = 2'h0;
  localparam logic [1:0] ZC_ZERO = 2'h1;
  localparam logic [1:0] ZC_ZERO_LOCK = 2'h2;
  localparam logic [1:0] ZC_CMD_LOCK = 2'h3;
  localparam logic [1:0] SRC_ANALOG = 2'h0;
  localparam logic [1:0] SRC_INT4 = 2'h1;
  localparam logic [1:0] SRC_INT3_AN = 2'h2;
  localparam logic [1:0] SRC_INT8 = 2'h3;
  localparam logic [1:0] LIM_ANALOG = 2'h1;
  localparam logic [2:0] LIMIT_IDX = 3'h3;
  // ----------------------------------------
  // lock state
  // ----------------------------------------
  typedef enum logic [1:0] {
    SPEED_CTRL = 2'b01,
    POS_LOCK = 2'b10
  } lock_state_t;
endpackage : speed_shaper_pkg

// >>> design/ms_tick.sv
module ms_tick #(
  parameter int CYCLES = speed_shaper_pkg::TICK_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  output logic tick
);
  logic [31:0] cnt_r, cnt_nxt;
  logic tick_r, tick_nxt;

  // count down one period, pulse on wrap
  always_comb begin
    tick_nxt = 1'b0;
    cnt_nxt = cnt_r - 32'h0000_0001;
    if (cnt_r == 32'h0000_0000) begin
      cnt_nxt = 32'(CYCLES - 1);
      tick_nxt = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= 32'h0000_0000;
      tick_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick = tick_r;
endmodule : ms_tick

// >>> design/speed_table.sv
module speed_table #(
  parameter int W = speed_shaper_pkg::SPD_W,
  parameter int DEPTH = speed_shaper_pkg::NUM_SPEEDS
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_idx,
  input wire logic [W-1:0] wr_data,
  input wire logic [$clog2(DEPTH)-1:0] rd_idx_a,
  input wire logic [$clog2(DEPTH)-1:0] rd_idx_b,
  output logic [W-1:0] rd_a,
  output logic [W-1:0] rd_b
);
  logic [W-1:0] mem_r [DEPTH];
  logic [W-1:0] rd_a_r, rd_b_r;

  // every entry resets to zero speed
  for (genvar i = 0; i < DEPTH; i++) begin : g_ent
    always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
        mem_r[i] <= '0;
      end else if (wr_en && wr_idx == i) begin
        mem_r[i] <= wr_data;
      end
    end
  end

  // registered read ports
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_a_r <= '0;
      rd_b_r <= '0;
    end else begin
      rd_a_r <= mem_r[rd_idx_a];
      rd_b_r <= mem_r[rd_idx_b];
    end
  end

  assign rd_a = rd_a_r;
  assign rd_b = rd_b_r;
endmodule : speed_table

// >>> design/speed_command_shaper.sv
module speed_command_shaper #(
  parameter int TICK_CYCLES = speed_shaper_pkg::TICK_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic signed [15:0] analog_cmd,
  input wire logic analog_direction_swap,
  input wire logic [1:0] speed_source_select,
  input wire logic [2:0] speed_contacts,
  input wire logic speed_wr_en,
  input wire logic [2:0] speed_wr_idx,
  input wire logic signed [15:0] speed_wr_data,
  input wire logic [15:0] overspeed_level,
  input wire logic [13:0] accel_time,
  input wire logic [13:0] decel_time,
  input wire logic [9:0] scurve_time,
  input wire logic [1:0] zero_clamp_select,
  input wire logic zero_speed_in,
  input wire logic [15:0] lock_level,
  input wire logic signed [15:0] actual_speed,
  input wire logic [1:0] force_cmd_limit_source,
  input wire logic [15:0] analog_speed_limit,
  output logic signed [15:0] speed_cmd,
  output logic position_lock,
  output logic pos_cmd_zero,
  output logic [15:0] force_speed_limit
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [15:0] mag(input logic signed [15:0] v);
    mag = v[15] ? 16'(-v) : 16'(v);
  endfunction : mag

  // floor log2 of the S-curve window in ms
  function automatic logic [4:0] win_shift(input logic [9:0] ts);
    logic [10:0] w;
    w = {ts, 1'b0};
    win_shift = 5'h00;
    for (int i = 0; i < 11; i++) begin
      if (w[i]) begin
        win_shift = 5'(i);
      end
    end
  endfunction : win_shift

  // ----------------------------------------
  // timebase and speed table
  // ----------------------------------------
  logic tick;
  logic [2:0] rd_idx;
  logic [15:0] sel_raw, lim_raw;

  ms_tick #(.CYCLES(TICK_CYCLES)) u_tick (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .tick(tick)
  );

  speed_table u_table (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .wr_en(speed_wr_en),
    .wr_idx(speed_wr_idx),
    .wr_data(speed_wr_data),
    .rd_idx_a(rd_idx),
    .rd_idx_b(speed_shaper_pkg::LIMIT_IDX),
    .rd_a(sel_raw),
    .rd_b(lim_raw)
  );

  // ----------------------------------------
  // target selection
  // ----------------------------------------
  logic use_analog;
  logic zero_force;
  logic signed [15:0] analog_dir, int_clamped, lim_clamped;
  logic signed [15:0] target_r, target_nxt;
  logic from_int_r, from_int_nxt;

  // contacts pick the table entry per source setting
  always_comb begin
    rd_idx = {1'b0, speed_contacts[1:0]};
    use_analog = 1'b0;
    case (speed_source_select)
      speed_shaper_pkg::SRC_ANALOG: use_analog = 1'b1;
      speed_shaper_pkg::SRC_INT4: use_analog = 1'b0;
      speed_shaper_pkg::SRC_INT3_AN:
        use_analog = (speed_contacts[1:0] == 2'h3);
      speed_shaper_pkg::SRC_INT8: rd_idx = speed_contacts;
      default: use_analog = 1'b1;
    endcase
  end

  // polarity of the analog command
  always_comb begin
    analog_dir = analog_direction_swap ? 16'(-analog_cmd) : analog_cmd;
  end

  // magnitude clamp; selected speed keeps its sign, clamped limit goes positive
  always_comb begin
    int_clamped = sel_raw;
    if (mag(sel_raw) > overspeed_level) begin
      int_clamped = sel_raw[15] ? 16'(-overspeed_level) : overspeed_level;
    end
    lim_clamped = lim_raw;
    if (mag(lim_raw) > overspeed_level) begin
      lim_clamped = overspeed_level;
    end
  end

  // modes 1 and 2 zero the target; mode 3 leaves it
  always_comb begin
    zero_force = zero_speed_in &&
      (zero_clamp_select == speed_shaper_pkg::ZC_ZERO ||
       zero_clamp_select == speed_shaper_pkg::ZC_ZERO_LOCK);
    from_int_nxt = !use_analog;
    target_nxt = use_analog ? analog_dir : int_clamped;
    if (zero_force) begin
      target_nxt = '0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      target_r <= '0;
      from_int_r <= 1'b0;
    end else begin
      target_r <= target_nxt;
      from_int_r <= from_int_nxt;
    end
  end

  // ----------------------------------------
  // linear ramp
  // ----------------------------------------
  logic signed [15:0] ramp_r, ramp_nxt;
  logic [15:0] credit_r, credit_nxt;
  logic up, accel;
  logic [15:0] slope;
  logic [16:0] cr_sum;

  // credit per ms is 1000, one mm/s step costs the time setting
  always_comb begin
    up = target_r > ramp_r;
    accel = up ? (ramp_r >= 0) : (ramp_r <= 0);
    slope = accel ? {2'h0, accel_time} : {2'h0, decel_time};
    cr_sum = {1'b0, credit_r} +
      (tick ? {1'b0, speed_shaper_pkg::CREDIT_INC} : 17'h0_0000);
    if (cr_sum > {1'b0, speed_shaper_pkg::CREDIT_CAP}) begin
      cr_sum = {1'b0, speed_shaper_pkg::CREDIT_CAP};
    end
    ramp_nxt = ramp_r;
    credit_nxt = cr_sum[15:0];
    if (slope == 16'h0000) begin
      ramp_nxt = target_r;
      credit_nxt = '0;
    end else if (ramp_r == target_r) begin
      credit_nxt = '0;
    end else if (cr_sum[15:0] >= slope) begin
      ramp_nxt = up ? ramp_r + 16'sd1 : ramp_r - 16'sd1;
      credit_nxt = cr_sum[15:0] - slope;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ramp_r <= '0;
      credit_r <= '0;
    end else begin
      ramp_r <= ramp_nxt;
      credit_r <= credit_nxt;
    end
  end

  // ----------------------------------------
  // pseudo S-curve smoothing
  // ----------------------------------------
  logic signed [15:0] smooth_r, smooth_nxt;
  logic signed [16:0] gap, part;

  // per ms, close a power-of-two share of the gap
  always_comb begin
    gap = 17'(ramp_r) - 17'(smooth_r);
    part = gap >>> win_shift(scurve_time);
    if (part == 17'sd0 && gap != 17'sd0) begin
      part = gap[16] ? -17'sd1 : 17'sd1;
    end
    smooth_nxt = smooth_r;
    if (scurve_time == 10'h000) begin
      smooth_nxt = ramp_r;
    end else if (tick) begin
      smooth_nxt = 16'(17'(smooth_r) + part);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      smooth_r <= '0;
    end else begin
      smooth_r <= smooth_nxt;
    end
  end

  // ----------------------------------------
  // position lock and force limit
  // ----------------------------------------
  speed_shaper_pkg::lock_state_t lock_r, lock_nxt;
  logic pos_zero_r, pos_zero_nxt;
  logic [15:0] flim_r, flim_nxt;
  logic act_slow, cmd_slow;

  // thresholds work on magnitude in either direction
  always_comb begin
    act_slow = mag(actual_speed) < lock_level;
    cmd_slow = mag(smooth_r) < lock_level;
  end

  // lock state machine
  always_comb begin
    lock_nxt = lock_r;
    case (lock_r)
      speed_shaper_pkg::SPEED_CTRL: begin
        if (zero_speed_in && act_slow &&
            zero_clamp_select == speed_shaper_pkg::ZC_ZERO_LOCK) begin
          lock_nxt = speed_shaper_pkg::POS_LOCK;
        end
        if (zero_speed_in && cmd_slow &&
            zero_clamp_select == speed_shaper_pkg::ZC_CMD_LOCK) begin
          lock_nxt = speed_shaper_pkg::POS_LOCK;
        end
      end
      speed_shaper_pkg::POS_LOCK: begin
        if (!zero_speed_in ||
            zero_clamp_select == speed_shaper_pkg::ZC_OFF ||
            zero_clamp_select == speed_shaper_pkg::ZC_ZERO) begin
          lock_nxt = speed_shaper_pkg::SPEED_CTRL;
        end
      end
      default: lock_nxt = speed_shaper_pkg::SPEED_CTRL;
    endcase
    // mode 2 lock holds a zero position command
    pos_zero_nxt = (lock_nxt == speed_shaper_pkg::POS_LOCK) &&
      (zero_clamp_select == speed_shaper_pkg::ZC_ZERO_LOCK);
    // force control speed limit source
    flim_nxt = (force_cmd_limit_source == speed_shaper_pkg::LIM_ANALOG) ?
      analog_speed_limit : mag(lim_clamped);
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      lock_r <= speed_shaper_pkg::SPEED_CTRL;
      pos_zero_r <= 1'b0;
      flim_r <= '0;
    end else begin
      lock_r <= lock_nxt;
      pos_zero_r <= pos_zero_nxt;
      flim_r <= flim_nxt;
    end
  end

  assign speed_cmd = smooth_r;
  assign position_lock = lock_r[1]; // one-hot lock bit, straight from flop
  assign pos_cmd_zero = pos_zero_r;
  assign force_speed_limit = flim_r;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  sequence analog_src_s;
    speed_source_select == speed_shaper_pkg::SRC_ANALOG && !zero_force;
  endsequence

  sequence zero_held_s;
    (zero_speed_in && zero_clamp_select == speed_shaper_pkg::ZC_ZERO)[*2];
  endsequence

  sequence slow_mode2_s;
    zero_speed_in && act_slow &&
      zero_clamp_select == speed_shaper_pkg::ZC_ZERO_LOCK;
  endsequence

  chk_analog_polarity: assert property (
    analog_src_s |=> target_r == (($past(analog_direction_swap)) ?
      16'(-$past(analog_cmd)) : $past(analog_cmd)))
    else $error("analog polarity wrong");

  chk_speed_clamp: assert property (
    from_int_r |-> mag(target_r) <= $past(overspeed_level))
    else $error("internal speed above overspeed level");

  chk_ramp_bypass: assert property (
    accel_time == 14'h0000 && decel_time == 14'h0000
      |=> ramp_r == $past(target_r))
    else $error("ramp not bypassed with zero times");

  chk_ramp_step: assert property (
    $past(slope) != 16'h0000 |->
      ramp_r - $past(ramp_r) inside {-16'sd1, 16'sd0, 16'sd1})
    else $error("ramp moved more than one step");

  chk_zero_mode1: assert property (
    zero_held_s |=> target_r == 16'sd0 && !position_lock)
    else $error("mode 1 did not zero the target");

  chk_lock_mode2: assert property (
    slow_mode2_s |=> position_lock ##0 pos_cmd_zero)
    else $error("mode 2 lock not taken");

  chk_unlock_release: assert property (
    position_lock && !zero_speed_in |=> !position_lock && !pos_cmd_zero)
    else $error("lock held after zero input released");

  chk_mode3_lock: assert property (
    zero_clamp_select == speed_shaper_pkg::ZC_CMD_LOCK && !position_lock
      && !(zero_speed_in && cmd_slow) |=> !position_lock ##0 !pos_cmd_zero)
    else $error("mode 3 lock without both conditions");

  chk_mode0_idle: assert property (
    zero_clamp_select == speed_shaper_pkg::ZC_OFF [*2] |-> !position_lock)
    else $error("lock active with function disabled");

  chk_force_limit: assert property (
    force_cmd_limit_source == speed_shaper_pkg::LIM_ANALOG
      |=> force_speed_limit == $past(analog_speed_limit))
    else $error("force limit not from analog input");
endmodule : speed_command_shaper

// >>> test/host_model.sv
module host_model (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic signed [15:0] want_cmd,
  input wire logic want_zero,
  input wire logic signed [15:0] want_meas,
  output logic signed [15:0] analog_cmd,
  output logic zero_speed_in,
  output logic signed [15:0] actual_speed
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------
  // host outputs
  // ------------------------------
  // host lowers its command itself in cmd-lock mode
  // clamp modes only used in speed control
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      analog_cmd <= 16'sh0000;
      zero_speed_in <= 1'b0;
      actual_speed <= 16'sh0000;
    end else begin
      analog_cmd <= want_cmd;
      zero_speed_in <= want_zero;
      actual_speed <= want_meas;
    end
  end
endmodule : host_model

// >>> test/test_speed_command_shaper.sv
module test_speed_command_shaper;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic signed [15:0] want_cmd = '0, want_meas = '0;
  logic want_zero = 1'b0;
  logic signed [15:0] analog_cmd, actual_speed, speed_cmd;
  logic zero_speed_in, position_lock, pos_cmd_zero;
  logic swp = 1'b0;
  logic [1:0] src = 2'h0, zc = 2'h0, lim_src = 2'h0;
  logic [2:0] pick = 3'h0, wr_idx = 3'h0;
  logic wr_en = 1'b0;
  logic signed [15:0] wr_data = '0;
  logic [15:0] ovs = 16'h03e8, lock_lv = 16'h0064, an_lim = 16'h0fa0;
  logic [13:0] acc = '0, dec = '0;
  logic [9:0] scv = '0;
  logic [15:0] force_speed_limit;
  int failures = 0, samples_checked = 0, cyc = 0;
  logic signed [15:0] tbl [8] = '{100, -200, 300, -400, 5000, -600, 700,
                                  -20000};

  always #10 sys_clk = ~sys_clk;

  host_model host (.sys_clk(sys_clk), .rst_b(rst_b), .want_cmd(want_cmd),
    .want_zero(want_zero), .want_meas(want_meas), .analog_cmd(analog_cmd),
    .zero_speed_in(zero_speed_in), .actual_speed(actual_speed));

  speed_command_shaper #(.TICK_CYCLES(50)) DUT (.sys_clk(sys_clk),
    .rst_b(rst_b), .analog_cmd(analog_cmd), .analog_direction_swap(swp),
    .speed_source_select(src), .speed_contacts(pick), .speed_wr_en(wr_en),
    .speed_wr_idx(wr_idx), .speed_wr_data(wr_data), .overspeed_level(ovs),
    .accel_time(acc), .decel_time(dec), .scurve_time(scv),
    .zero_clamp_select(zc), .zero_speed_in(zero_speed_in),
    .lock_level(lock_lv), .actual_speed(actual_speed),
    .force_cmd_limit_source(lim_src), .analog_speed_limit(an_lim),
    .speed_cmd(speed_cmd), .position_lock(position_lock),
    .pos_cmd_zero(pos_cmd_zero), .force_speed_limit(force_speed_limit));

  // ------------------------------
  // shared helpers
  // ------------------------------
  task automatic results();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task automatic cyc_wait(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : cyc_wait

  // polls the command until it matches or the limit runs out
  task automatic wait_cmd(input logic [15:0] e, input int lim);
    int i;
    @(negedge sys_clk);
    for (i = 0; i < lim && speed_cmd !== e; i++) cyc_wait(1);
    chk("speed_cmd", e, speed_cmd);
  endtask : wait_cmd

  task automatic wr(input logic [2:0] idx, input logic signed [15:0] v);
    @(posedge sys_clk);
    wr_en <= 1'b1;
    wr_idx <= idx;
    wr_data <= v;
    @(posedge sys_clk);
    wr_en <= 1'b0;
  endtask : wr

  // ------------------------------
  // scenarios
  // ------------------------------
  task automatic t_reset();
    chk("speed_cmd", 16'h0000, speed_cmd);
    chk("position_lock", 16'h0000, position_lock);
    chk("force_limit", 16'h0000, force_speed_limit);
    $display("test reset done");
  endtask : t_reset

  task automatic t_swap();
    @(posedge sys_clk);
    want_cmd <= 16'sh012c;
    wait_cmd(16'h012c, 8);
    @(posedge sys_clk);
    swp <= 1'b1;
    wait_cmd(16'hfed4, 8);
    @(posedge sys_clk);
    swp <= 1'b0;
    $display("test swap done");
  endtask : t_swap

  task automatic t_table();
    int i;
    logic signed [15:0] e;
    for (i = 0; i < 8; i++) wr(3'(i), tbl[i]);
    @(posedge sys_clk);
    src <= 2'h3;
    for (i = 0; i < 8; i++) begin
      @(posedge sys_clk);
      pick <= 3'(i);
      e = tbl[i] > 1000 ? 16'sd1000 : tbl[i] < -1000 ? -16'sd1000 : tbl[i];
      wait_cmd(e, 8);
    end
    @(posedge sys_clk);
    src <= 2'h2;
    pick <= 3'h3;
    wait_cmd(16'h012c, 8);
    @(posedge sys_clk);
    src <= 2'h1;
    wait_cmd(16'hfe70, 8);
    cyc_wait(2);
    chk("force_limit", 16'h0190, force_speed_limit);
    @(posedge sys_clk);
    lim_src <= 2'h1;
    cyc_wait(3);
    chk("force_limit", 16'h0fa0, force_speed_limit);
    @(posedge sys_clk);
    src <= 2'h0;
    want_cmd <= 16'sh0000;
    wait_cmd(16'h0000, 8);
    $display("test table done");
  endtask : t_table

  task automatic t_ramp();
    @(posedge sys_clk);
    acc <= 14'h03e8;
    want_cmd <= 16'sh0014;
    cyc_wait(10);
    chk("ramping", 16'h0001, speed_cmd != 16'sh0014);
    wait_cmd(16'h0014, 1500);
    @(posedge sys_clk);
    want_cmd <= 16'sh0000;
    wait_cmd(16'h0000, 10);
    @(posedge sys_clk);
    acc <= 14'h0020; // half of each ramp time above S-curve width
    dec <= 14'h0020;
    scv <= 10'h005;
    want_cmd <= 16'sh0032;
    wait_cmd(16'h0032, 3000);
    @(posedge sys_clk);
    scv <= 10'h000;
    acc <= 14'h0000;
    dec <= 14'h0000;
    $display("test ramp done");
  endtask : t_ramp

  task automatic t_clamp();
    // times at zero as an outer loop host would leave them
    @(posedge sys_clk);
    want_cmd <= 16'sh012c;
    want_zero <= 1'b1;
    wait_cmd(16'h012c, 8);
    @(posedge sys_clk);
    zc <= 2'h1;
    want_meas <= -16'sd150;
    wait_cmd(16'h0000, 8);
    @(posedge sys_clk);
    zc <= 2'h2;
    want_meas <= -16'sd150;
    cyc_wait(4);
    chk("position_lock", 16'h0000, position_lock);
    @(posedge sys_clk);
    want_meas <= -16'sd50;
    cyc_wait(4);
    chk("position_lock", 16'h0001, position_lock);
    chk("pos_cmd_zero", 16'h0001, pos_cmd_zero);
    chk("speed_cmd", 16'h0000, speed_cmd);
    @(posedge sys_clk);
    want_zero <= 1'b0;
    cyc_wait(4);
    chk("position_lock", 16'h0000, position_lock);
    wait_cmd(16'h012c, 8);
    @(posedge sys_clk);
    zc <= 2'h3;
    want_zero <= 1'b1;
    cyc_wait(6);
    chk("speed_cmd", 16'h012c, speed_cmd);
    chk("position_lock", 16'h0000, position_lock);
    @(posedge sys_clk);
    want_cmd <= 16'sh0032;
    cyc_wait(6);
    chk("position_lock", 16'h0001, position_lock);
    @(posedge sys_clk);
    want_zero <= 1'b0;
    zc <= 2'h0;
    $display("test clamp done");
  endtask : t_clamp

  // ------------------------------
  // run control
  // ------------------------------
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 60000) begin
      failures++;
      results();
    end
  end

  initial begin
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    cyc_wait(1);
    t_reset();
    t_swap();
    t_table();
    t_ramp();
    t_clamp();
    results();
  end
endmodule : test_speed_command_shaper
